// File: src/tc2_timer2_capture_compare.sv
// tc2_timer2_capture_compare: 16-bit timer with prescaler, reload, four capture
// and three compare channels driving port 4, behind an ahb-lite slave
// assumes one ahb master, word transfers only, and asynchronous input pins
`timescale 1ns/1ns
module tc2_timer2_capture_compare
  import tc2_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic timer_count_pin,
  input wire logic [3:0] capture_input,
  output logic [7:0] port4_out,
  output logic timer_irq,
  output logic [6:0] cap_cmp_irq
);
  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  logic wr_q, rd_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;
  logic take;

  assign take = hsel & hready & htrans[1];
  // reads take one wait state so the data word is registered
  assign hreadyout = ~rd_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= TC2_RST_BYTE;
    end else begin
      wr_q <= take & hwrite;
      rd_q <= take & ~hwrite & ~rd_q;
      if (take) begin
        addr_q <= {haddr[7:2], 2'b00};
      end
    end
  end

  // read data register, loaded during the wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_q) begin
      hrdata_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // control and status registers
  // ----------------------------------------------------------------
  logic down_q, src_q, run_q, wflag_q, bflag_q, bsel_q, wsel_q, t2m_q, x4_q;
  logic [1:0] presc_q, cd_q;
  logic [15:0] count_q, reload_q;
  logic [7:0] edge_q, eie_q, compare_set_enable_q, compare_reset_toggle_enable_q;
  logic [6:0] flags_q;
  logic [5:0] latch_q, latch_d;
  logic [15:0] cap_q [4];
  logic [15:0] cmp_q [3];
  logic [3:0] cap_ev;
  logic [2:0] hit_q;
  logic tick, byte_ev, word_ev;

  function automatic logic w_at(input logic [7:0] ofs);
    w_at = wr_q && (addr_q == ofs);
  endfunction

  // plain configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      down_q <= 1'b0;
      src_q <= 1'b0;
      run_q <= 1'b0;
      presc_q <= 2'h0;
      bsel_q <= 1'b0;
      wsel_q <= 1'b0;
      t2m_q <= 1'b0;
      cd_q <= TC2_RST_CD;
      x4_q <= 1'b0;
      reload_q <= TC2_RST_WORD;
      edge_q <= TC2_RST_BYTE;
      eie_q <= TC2_RST_BYTE;
      compare_reset_toggle_enable_q <= TC2_RST_BYTE;
    end else begin
      if (w_at(TC2_OFS_CTRL)) begin
        down_q <= hwdata[TC2_B_DOWN];
        src_q <= hwdata[TC2_B_SRC];
        run_q <= hwdata[TC2_B_RUN];
      end
      if (w_at(TC2_OFS_SEL)) begin
        presc_q <= hwdata[1:0];
        bsel_q <= hwdata[TC2_B_BSEL];
        wsel_q <= hwdata[TC2_B_WSEL];
      end
      if (w_at(TC2_OFS_CLKCTL)) begin
        t2m_q <= hwdata[TC2_B_T2M];
      end
      if (w_at(TC2_OFS_PMODE)) begin
        cd_q <= hwdata[TC2_B_CD+1:TC2_B_CD];
        x4_q <= hwdata[TC2_B_X4];
      end
      if (w_at(TC2_OFS_RELOAD)) begin
        reload_q <= hwdata[15:0];
      end
      if (w_at(TC2_OFS_EDGE)) begin
        edge_q <= hwdata[7:0];
      end
      if (w_at(TC2_OFS_EIE)) begin
        eie_q <= hwdata[7:0];
      end
      if (w_at(TC2_OFS_COMPARE_RESET_TOGGLE_ENABLE)) begin
        compare_reset_toggle_enable_q <= hwdata[7:0];
      end
    end
  end

  // compare values, written before the compare is put to use
  generate
    for (genvar c = 0; c < 3; c++) begin : g_cmp
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cmp_q[c] <= TC2_RST_WORD;
        end else if (w_at(TC2_OFS_CMP0 + 8'(4 * c))) begin
          cmp_q[c] <= hwdata[15:0];
        end
      end
    end
  endgenerate

  // register read mux
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (addr_q)
      TC2_OFS_CTRL: rd_mux[7:0] = {wflag_q, 4'h0, run_q, src_q, down_q};
      TC2_OFS_SEL: rd_mux[7:0] = {wsel_q, bsel_q, 1'b0, bflag_q, 2'h0, presc_q};
      TC2_OFS_CLKCTL: rd_mux[TC2_B_T2M] = t2m_q;
      TC2_OFS_PMODE: rd_mux[7:0] = {cd_q, 2'h0, x4_q, 3'h0};
      TC2_OFS_COUNT: rd_mux[15:0] = count_q;
      TC2_OFS_RELOAD: rd_mux[15:0] = reload_q;
      TC2_OFS_EDGE: rd_mux[7:0] = edge_q;
      TC2_OFS_FLAGS: rd_mux[6:0] = flags_q;
      TC2_OFS_EIE: rd_mux[7:0] = eie_q;
      TC2_OFS_COMPARE_SET_ENABLE: rd_mux[7:0] = compare_set_enable_q;
      TC2_OFS_COMPARE_RESET_TOGGLE_ENABLE: rd_mux[7:0] = compare_reset_toggle_enable_q;
      8'h2c: rd_mux[15:0] = cap_q[0];
      8'h30: rd_mux[15:0] = cap_q[1];
      8'h34: rd_mux[15:0] = cap_q[2];
      8'h38: rd_mux[15:0] = cap_q[3];
      8'h3c: rd_mux[15:0] = cmp_q[0];
      8'h40: rd_mux[15:0] = cmp_q[1];
      8'h44: rd_mux[15:0] = cmp_q[2];
      TC2_OFS_PORT: rd_mux[5:0] = latch_q;
      default: rd_mux = 32'h0000_0000; // unmapped words read zero
    endcase
  end

  // ----------------------------------------------------------------
  // input synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [4:0] meta_q, sync_q, prev_q, rise, fall;

  // bit 0 is the count pin, bits 4:1 the capture inputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // idle-high pin level, so no false edge follows reset
      meta_q <= 5'h1f;
      sync_q <= 5'h1f;
      prev_q <= 5'h1f;
    end else begin
      meta_q <= {capture_input, timer_count_pin};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

  // ----------------------------------------------------------------
  // clock source, prescaler and counter
  // ----------------------------------------------------------------
  logic [11:0] div_cnt_q, div_max, mc_div;
  logic [2:0] pre_cnt_q, pre_max;
  logic int_tick, src_tick;

  // machine cycle divide from the clock divide bits
  always_comb begin
    unique case (cd_q)
      2'h0: mc_div = x4_q ? TC2_MC_CD0_4X : TC2_MC_CD0_2X;
      2'h1, 2'h2: mc_div = TC2_MC_CD12;
      default: mc_div = TC2_MC_CD3;
    endcase
    div_max = 12'(mc_div * (t2m_q ? TC2_DIV_FAST : TC2_DIV_SLOW) - 12'h001);
  end

  assign int_tick = (div_cnt_q >= div_max);
  assign src_tick = run_q & (src_q ? fall[0] : int_tick);
  assign pre_max = 3'((4'h1 << presc_q) - 4'h1);
  assign tick = src_tick & (pre_cnt_q >= pre_max);

  // internal base divider
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_q <= 12'h000;
    end else begin
      div_cnt_q <= int_tick ? 12'h000 : div_cnt_q + 12'h001;
    end
  end

  // prescaler
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_cnt_q <= 3'h0;
    end else if (src_tick) begin
      pre_cnt_q <= tick ? 3'h0 : pre_cnt_q + 3'h1;
    end
  end

  // overflow events in the count direction
  assign byte_ev = tick & (down_q ? count_q[7:0] == 8'h00 : count_q[7:0] == 8'hff);
  assign word_ev = tick & (down_q ? count_q == 16'h0000 : count_q == 16'hffff);

  // counter with auto-reload, software load wins over a step
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= TC2_RST_WORD;
    end else if (w_at(TC2_OFS_COUNT)) begin
      count_q <= hwdata[15:0];
    end else if (word_ev) begin
      count_q <= reload_q;
    end else if (tick) begin
      count_q <= down_q ? count_q - 16'h0001 : count_q + 16'h0001;
    end
  end

  // overflow flags, set beats a software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wflag_q <= 1'b0;
      bflag_q <= 1'b0;
    end else begin
      if (w_at(TC2_OFS_CTRL)) begin
        wflag_q <= hwdata[TC2_B_WFLAG] | word_ev;
      end else if (word_ev) begin
        wflag_q <= 1'b1;
      end
      if (w_at(TC2_OFS_SEL)) begin
        bflag_q <= hwdata[TC2_B_BFLAG] | byte_ev | word_ev;
      end else if (byte_ev | word_ev) begin
        bflag_q <= 1'b1;
      end
    end
  end

  // shared timer interrupt
  assign timer_irq = eie_q[TC2_B_ET2] & ((bflag_q & bsel_q) | (wflag_q & wsel_q));

  // ----------------------------------------------------------------
  // capture and compare channels
  // ----------------------------------------------------------------
  logic step_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_q <= 1'b0;
    end else begin
      step_q <= tick;
    end
  end

  generate
    for (genvar n = 0; n < 4; n++) begin : g_cap
      // one edge selection for capture and external interrupt
      assign cap_ev[n] = (rise[n+1] & edge_q[2*n]) | (fall[n+1] & edge_q[2*n+1]);
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cap_q[n] <= TC2_RST_WORD;
        end else if (cap_ev[n]) begin
          cap_q[n] <= count_q;
        end
      end
    end
    for (genvar c = 0; c < 3; c++) begin : g_hit
      // compare the value reached by the last step
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          hit_q[c] <= 1'b0;
        end else begin
          hit_q[c] <= step_q & (count_q == cmp_q[c]);
        end
      end
    end
  endgenerate

  // capture/interrupt and compare flags, set beats a software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= 7'h00;
    end else if (w_at(TC2_OFS_FLAGS)) begin
      flags_q <= hwdata[6:0] | {hit_q, cap_ev};
    end else begin
      flags_q <= flags_q | {hit_q, cap_ev};
    end
  end

  assign cap_cmp_irq = flags_q & eie_q[6:0];

  // port latch: reset enables, then set enables, zero bits untouched
  always_comb begin
    latch_d = w_at(TC2_OFS_PORT) ? hwdata[5:0] : latch_q;
    if (hit_q[1]) begin
      latch_d = latch_d & ~compare_reset_toggle_enable_q[5:0];
    end
    if (hit_q[0]) begin
      latch_d = latch_d | compare_set_enable_q[5:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_q <= 6'h00;
    end else begin
      latch_q <= latch_d;
    end
  end

  // set-enable register; its top bits are the toggle flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_set_enable_q <= TC2_RST_BYTE;
    end else begin
      if (w_at(TC2_OFS_COMPARE_SET_ENABLE)) begin
        compare_set_enable_q <= hwdata[7:0];
      end
      if (hit_q[2]) begin
        compare_set_enable_q[7:6] <= (w_at(TC2_OFS_COMPARE_SET_ENABLE) ? hwdata[7:6] : compare_set_enable_q[7:6])
                       ^ compare_reset_toggle_enable_q[7:6];
      end
    end
  end

  assign port4_out = {compare_set_enable_q[7:6], latch_q};

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_word_ev;
    word_ev && !w_at(TC2_OFS_CTRL) && !w_at(TC2_OFS_SEL);
  endsequence
  sequence s_read;
    take && !hwrite && !rd_q;
  endsequence

  property p_word_sets_both;
    @(posedge hclk) disable iff (!hresetn) s_word_ev |=> wflag_q && bflag_q;
  endproperty
  a_word_sets_both: assert property (p_word_sets_both) else $error("word overflow flags");

  property p_flag_sticky;
    @(posedge hclk) disable iff (!hresetn)
      wflag_q && !w_at(TC2_OFS_CTRL) |=> wflag_q;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("overflow flag lost");

  property p_halt;
    @(posedge hclk) disable iff (!hresetn)
      !run_q && !w_at(TC2_OFS_COUNT) |=> $stable(count_q);
  endproperty
  a_halt: assert property (p_halt) else $error("count moved while halted");

  property p_irq_word;
    @(posedge hclk) disable iff (!hresetn)
      wflag_q && wsel_q && eie_q[TC2_B_ET2] |-> timer_irq;
  endproperty
  a_irq_word: assert property (p_irq_word) else $error("timer irq missing");

  property p_capture;
    @(posedge hclk) disable iff (!hresetn) cap_ev[0] |=> cap_q[0] == $past(count_q);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_cap_flag;
    @(posedge hclk) disable iff (!hresetn)
      fall[1] && edge_q[1] |=> flags_q[0];
  endproperty
  a_cap_flag: assert property (p_cap_flag) else $error("capture flag missing");

  property p_cmp_flag;
    @(posedge hclk) disable iff (!hresetn)
      tick && !w_at(TC2_OFS_COUNT) && !word_ev && !down_q
      && (16'(count_q + 16'h0001) == cmp_q[0]) |-> ##3 flags_q[4];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag late");

  property p_set_port;
    @(posedge hclk) disable iff (!hresetn)
      hit_q[0] |=> (latch_q & $past(compare_set_enable_q[5:0])) == $past(compare_set_enable_q[5:0]);
  endproperty
  a_set_port: assert property (p_set_port) else $error("set enables ignored");

  property p_toggle;
    @(posedge hclk) disable iff (!hresetn)
      hit_q[2] && compare_reset_toggle_enable_q[7] && !w_at(TC2_OFS_COMPARE_SET_ENABLE) |=> port4_out[7] != $past(port4_out[7]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle flop did not toggle");

  property p_read_wait;
    @(posedge hclk) disable iff (!hresetn) s_read |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
endmodule

// File: src/tc2_pkg.sv
// tc2_pkg: register map, field positions and reset values of the timer 2 block
// assumes a 32-bit ahb-lite slave port with one aligned word per register
package tc2_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TC2_OFS_CTRL = 8'h00; // timer_control_reg
  localparam logic [7:0] TC2_OFS_SEL = 8'h04; // timer_select_reg
  localparam logic [7:0] TC2_OFS_CLKCTL = 8'h08; // clock_control_reg
  localparam logic [7:0] TC2_OFS_PMODE = 8'h0c; // power_mode_reg
  localparam logic [7:0] TC2_OFS_COUNT = 8'h10; // timer high:low byte
  localparam logic [7:0] TC2_OFS_RELOAD = 8'h14; // reload high:low byte
  localparam logic [7:0] TC2_OFS_EDGE = 8'h18; // capture_edge_select
  localparam logic [7:0] TC2_OFS_FLAGS = 8'h1c; // capture_compare_flag_reg
  localparam logic [7:0] TC2_OFS_EIE = 8'h20; // extended_irq_enable_reg
  localparam logic [7:0] TC2_OFS_COMPARE_SET_ENABLE = 8'h24; // compare_set_enable
  localparam logic [7:0] TC2_OFS_COMPARE_RESET_TOGGLE_ENABLE = 8'h28; // compare_reset_toggle_enable
  localparam logic [7:0] TC2_OFS_CAP0 = 8'h2c; // capture 0..3 at +4 each
  localparam logic [7:0] TC2_OFS_CMP0 = 8'h3c; // compare 0..2 at +4 each
  localparam logic [7:0] TC2_OFS_PORT = 8'h48; // port 4 latch bits 5:0
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TC2_B_DOWN = 0; // count direction, 1 = down
  localparam int TC2_B_SRC = 1; // count_source_select
  localparam int TC2_B_RUN = 2; // timer_run_enable
  localparam int TC2_B_WFLAG = 7; // word_overflow_flag
  localparam int TC2_B_BFLAG = 4; // byte_overflow_flag
  localparam int TC2_B_BSEL = 6; // byte_overflow_irq_sel
  localparam int TC2_B_WSEL = 7; // word_overflow_irq_sel
  localparam int TC2_B_T2M = 5; // timer_clock_rate_select
  localparam int TC2_B_X4 = 3; // four-clock machine cycle
  localparam int TC2_B_CD = 6; // clock_divide_lo, hi at +1
  localparam int TC2_B_ET2 = 7; // timer_irq_enable
  // ----------------------------------------------------------------
  // reset values and divider constants
  // ----------------------------------------------------------------
  localparam logic [7:0] TC2_RST_BYTE = 8'h00;
  localparam logic [15:0] TC2_RST_WORD = 16'h0000;
  localparam logic [1:0] TC2_RST_CD = 2'h0;
  localparam logic [11:0] TC2_DIV_FAST = 12'h001; // rate select 1
  localparam logic [11:0] TC2_DIV_SLOW = 12'h003; // rate select 0
  localparam logic [11:0] TC2_MC_CD0_4X = 12'h001;
  localparam logic [11:0] TC2_MC_CD0_2X = 12'h002;
  localparam logic [11:0] TC2_MC_CD12 = 12'h004;
  localparam logic [11:0] TC2_MC_CD3 = 12'h400;
endpackage

// File: verification/tc2_pin_model.sv
// tc2_pin_model: count and capture pins on the far side of the timer
// assumes its tasks are called just after a rising edge of hclk
`timescale 1ns/1ns
module tc2_pin_model (
  input wire logic hclk,
  output logic timer_count_pin,
  output logic [3:0] capture_input
);
  // ----------------------------------------------------------------
  // pin levels
  // ----------------------------------------------------------------
  // pins idle high and only move just after a rising edge
  initial begin
    timer_count_pin = 1'b1;
    capture_input = 4'hf;
  end
  // n falling edges; each level held long enough for the sync flops
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge hclk);
      timer_count_pin <= 1'b0;
      repeat (3) @(posedge hclk);
      timer_count_pin <= 1'b1;
      repeat (2) @(posedge hclk);
    end
  endtask
  // move one capture pin and hold it for three cycles
  task automatic cap(input int ch, input logic lvl);
    @(posedge hclk);
    capture_input[ch] <= lvl;
    repeat (3) @(posedge hclk);
  endtask
endmodule

// File: verification/test_timer2_capture_compare.sv
// test_timer2_capture_compare: self-checking bench for the timer 2 block
// assumes one ahb-lite master (this bench) and the pin model on the far side
`timescale 1ns/1ns
module test_timer2_capture_compare;
  import tc2_pkg::*;
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, timer_count_pin, timer_irq;
  logic [3:0] capture_input;
  logic [7:0] port4_out;
  logic [6:0] cap_cmp_irq;
  int miscompares = 0;
  int samples_checked = 0;
  // ----------------------------------------------------------------
  // design and far side
  // ----------------------------------------------------------------
  tc2_timer2_capture_compare i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timer_count_pin(timer_count_pin), .capture_input(capture_input),
    .port4_out(port4_out), .timer_irq(timer_irq), .cap_cmp_irq(cap_cmp_irq));
  tc2_pin_model i_pins (.hclk(hclk), .timer_count_pin(timer_count_pin),
    .capture_input(capture_input));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // clock at 4 ns
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // one ahb-lite single transfer; ready and read data taken before the edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    r = hrdata;
    @(posedge hclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(n, e, x);
  endtask
  // pin steps, then time for compare actions to land
  task automatic step(input int n);
    i_pins.pulses(n);
    repeat (4) @(posedge hclk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int a = 0; a <= 'h4c; a += 4) rd("reset reg", 8'(a), 32'h0);
    chk("port after reset", 32'h0, {24'h0, port4_out});
    chk("irq after reset", 32'h0, {24'h0, timer_irq, cap_cmp_irq});
    $display("test reset done");
  endtask
  task automatic t_regs();
    wr(TC2_OFS_EDGE, 32'hffff_ffa5);
    rd("edge select", TC2_OFS_EDGE, 32'ha5);
    wr(TC2_OFS_COMPARE_RESET_TOGGLE_ENABLE, 32'h5a);
    rd("reset enable", TC2_OFS_COMPARE_RESET_TOGGLE_ENABLE, 32'h5a);
    wr(TC2_OFS_RELOAD, 32'hcafe);
    rd("reload", TC2_OFS_RELOAD, 32'hcafe);
    wr(TC2_OFS_CAP0, 32'hffff);
    rd("capture read only", TC2_OFS_CAP0, 32'h0);
    wr(8'h4c, 32'hffff);
    rd("unmapped", 8'h4c, 32'h0);
    chk("okay response", 32'h0, {31'h0, hresp});
    wr(TC2_OFS_EDGE, 32'h0);
    wr(TC2_OFS_COMPARE_RESET_TOGGLE_ENABLE, 32'h0);
    $display("test registers done");
  endtask
  task automatic t_count();
    logic [31:0] c;
    int b;
    wr(TC2_OFS_COUNT, 32'h0);
    wr(TC2_OFS_CTRL, 32'h06);
    for (int s = 0; s < 4; s++) begin
      wr(TC2_OFS_SEL, 32'(s));
      step(2 << s);
      rd("prescaled count", TC2_OFS_COUNT, 32'(2 * s + 2));
    end
    wr(TC2_OFS_CTRL, 32'h02);
    step(3);
    rd("halted count", TC2_OFS_COUNT, 32'h8);
    wr(TC2_OFS_SEL, 32'h0);
    // passes: four-clock, four-clock slow rate, two-clock, divide 4; b = clocks per tick
    for (int k = 0; k < 4; k++) begin
      b = (k == 0) ? 1 : (k == 1) ? 3 : (k == 2) ? 2 : 4;
      wr(TC2_OFS_PMODE, (k < 2) ? 32'h08 : (k == 2) ? 32'h00 : 32'h40);
      wr(TC2_OFS_CLKCTL, (k == 1) ? 32'h0 : 32'h20);
      wr(TC2_OFS_COUNT, 32'h0);
      wr(TC2_OFS_CTRL, 32'h04);
      repeat (30) @(posedge hclk);
      wr(TC2_OFS_CTRL, 32'h0);
      bus(1'b0, TC2_OFS_COUNT, 32'h0, c);
      chk("internal rate", 32'h1, 32'(c >= 32 / b - 1 && c <= 32 / b + 1));
    end
    $display("test count done");
  endtask
  task automatic t_overflow();
    wr(TC2_OFS_RELOAD, 32'h1234);
    wr(TC2_OFS_COUNT, 32'h00ff);
    wr(TC2_OFS_SEL, 32'h40);
    wr(TC2_OFS_EIE, 32'h80);
    wr(TC2_OFS_CTRL, 32'h06);
    step(1);
    rd("byte carry", TC2_OFS_COUNT, 32'h0100);
    rd("byte flag", TC2_OFS_SEL, 32'h50);
    rd("no word flag", TC2_OFS_CTRL, 32'h06);
    chk("byte irq", 32'h1, {31'h0, timer_irq});
    wr(TC2_OFS_SEL, 32'h80);
    // irq is looked at once the write has settled
    @(negedge hclk);
    chk("word irq idle", 32'h0, {31'h0, timer_irq});
    @(posedge hclk);
    wr(TC2_OFS_COUNT, 32'hffff);
    step(1);
    rd("reload up", TC2_OFS_COUNT, 32'h1234);
    step(2);
    rd("word flag kept", TC2_OFS_CTRL, 32'h86);
    rd("both flags", TC2_OFS_SEL, 32'h90);
    chk("word irq", 32'h1, {31'h0, timer_irq});
    wr(TC2_OFS_EIE, 32'h0);
    @(negedge hclk);
    chk("irq masked", 32'h0, {31'h0, timer_irq});
    @(posedge hclk);
    wr(TC2_OFS_SEL, 32'h0);
    wr(TC2_OFS_COUNT, 32'h0);
    wr(TC2_OFS_CTRL, 32'h07);
    step(1);
    rd("reload down", TC2_OFS_COUNT, 32'h1234);
    rd("down flags", TC2_OFS_CTRL, 32'h87);
    wr(TC2_OFS_CTRL, 32'h0);
    wr(TC2_OFS_SEL, 32'h0);
    $display("test overflow done");
  endtask
  task automatic t_capture();
    wr(TC2_OFS_EIE, 32'h0f);
    for (int ch = 0; ch < 4; ch++) begin
      wr(TC2_OFS_EDGE, 32'(2) << (2 * ch));
      wr(TC2_OFS_COUNT, 32'h0a50 + 32'(ch));
      wr(TC2_OFS_FLAGS, 32'h0);
      i_pins.cap(ch, 1'b0);
      rd("capture", TC2_OFS_CAP0 + 8'(4 * ch), 32'h0a50 + 32'(ch));
      rd("fall flag", TC2_OFS_FLAGS, 32'(1) << ch);
      chk("capture irq", 32'(1) << ch, {25'h0, cap_cmp_irq});
      wr(TC2_OFS_FLAGS, 32'h0);
      i_pins.cap(ch, 1'b1);
      rd("rise ignored", TC2_OFS_FLAGS, 32'h0);
    end
    wr(TC2_OFS_EDGE, 32'h01);
    i_pins.cap(0, 1'b0);
    rd("fall ignored", TC2_OFS_FLAGS, 32'h0);
    wr(TC2_OFS_COUNT, 32'h0777);
    i_pins.cap(0, 1'b1);
    rd("rise flag", TC2_OFS_FLAGS, 32'h01);
    rd("rise capture", TC2_OFS_CAP0, 32'h0777);
    wr(TC2_OFS_FLAGS, 32'h0);
    $display("test capture done");
  endtask
  task automatic t_compare();
    wr(TC2_OFS_EIE, 32'h70);
    wr(TC2_OFS_PORT, 32'h0);
    wr(TC2_OFS_CMP0, 32'h1);
    wr(TC2_OFS_CMP0 + 8'h4, 32'h2);
    wr(TC2_OFS_CMP0 + 8'h8, 32'h3);
    wr(TC2_OFS_COMPARE_SET_ENABLE, 32'h05);
    wr(TC2_OFS_COMPARE_RESET_TOGGLE_ENABLE, 32'h81);
    wr(TC2_OFS_COUNT, 32'h0);
    wr(TC2_OFS_CTRL, 32'h06);
    step(1);
    chk("set match", 32'h05, {24'h0, port4_out});
    rd("set flag", TC2_OFS_FLAGS, 32'h10);
    step(1);
    chk("reset match", 32'h04, {24'h0, port4_out});
    step(1);
    chk("toggle match", 32'h84, {24'h0, port4_out});
    rd("toggle flop", TC2_OFS_COMPARE_SET_ENABLE, 32'h85);
    rd("port latch", TC2_OFS_PORT, 32'h04);
    step(1);
    chk("no match", 32'h84, {24'h0, port4_out});
    rd("compare flags", TC2_OFS_FLAGS, 32'h70);
    chk("compare irq", 32'h70, {25'h0, cap_cmp_irq});
    wr(TC2_OFS_CTRL, 32'h0);
    $display("test compare done");
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_regs();
    t_count();
    t_overflow();
    t_capture();
    t_compare();
    results();
  end
  initial begin
    #200000;
    miscompares++;
    results();
  end
endmodule
